// ===== hdl/adoc_defines.svh
`ifndef ADOC_DEFINES_SVH
`define ADOC_DEFINES_SVH
// register byte addresses (one 32-bit word each)
`define ADOC_DRIVER_CONTROL_ADDR   8'h00
`define ADOC_P_COND_CW_ADDR        8'h04
`define ADOC_P_COND_MOD_ADDR       8'h08
`define ADOC_N_COND_ADDR           8'h0c
`define ADOC_TRANSMIT_MODE_ADDR    8'h10
`define ADOC_TRANSMIT_SEL_ADDR     8'h14
`define ADOC_STATUS_ADDR           8'h18
// driver control fields
`define ADOC_CTL_DRV1_ON           0
`define ADOC_CTL_DRV2_ON           1
`define ADOC_CTL_DRV2_CW           2
`define ADOC_CTL_DRV1_INV_ON       3
`define ADOC_CTL_DRV2_INV_ON       4
`define ADOC_CTL_DRV1_INV_OFF      5
`define ADOC_CTL_DRV2_INV_OFF      6
`define ADOC_CTL_FULL_ASK          7
// transmit mode fields
`define ADOC_MODE_RATE_LSB         4
`define ADOC_MODE_RATE_MSB         6
// transmit signal select fields
`define ADOC_SEL_ENV_LSB           4
`define ADOC_SEL_ENV_MSB           5
// n-conductance fields
`define ADOC_NCW_LSB               4
`define ADOC_NCW_MSB               7
`define ADOC_N_MOD_VALUE_LSB              0
`define ADOC_N_MOD_VALUE_MSB              3
// reset values
`define ADOC_CTL_RESET             8'h80
`define ADOC_P_CW_RESET            6'h3f
`define ADOC_P_MOD_RESET           6'h20
`define ADOC_N_RESET               8'h88
`define ADOC_MODE_RESET            8'h00
`define ADOC_SEL_RESET             8'h10
`define ADOC_OFF_SETTING           6'h00
`endif

// ===== hdl/adoc_pkg.sv
package adoc_pkg;
  typedef enum logic [1:0] {
    ADOC_ENV_CONST_HIGH,
    ADOC_ENV_INTERNAL,
    ADOC_ENV_EXT_MODEM,
    ADOC_ENV_CONST_LOW
  } adoc_env_src_t;

  typedef struct packed {
    logic       wave;
    logic [5:0] p_cond;
    logic [3:0] n_cond;
  } adoc_drive_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  addr;
  } adoc_req_t;
endpackage

// ===== hdl/adoc_driver_leg.sv
`timescale 1ns/100ps
`include "adoc_defines.svh"
module adoc_driver_leg (
  input  wire logic               carrier,
  input  wire logic               carrier_on,
  input  wire logic               envelope,
  input  wire logic               constant_wave,
  input  wire logic               invert_when_on,
  input  wire logic               full_depth_ask_force,
  input  wire logic [5:0]         p_cw_value,
  input  wire logic [5:0]         p_mod_value,
  input  wire logic [3:0]         n_cw_value,
  input  wire logic [3:0]         n_mod_value,
  output adoc_pkg::adoc_drive_t   drive
);
  wire use_cw;
  wire carrier_inverted;
  wire forced_low;
  wire wave;
  wire [5:0] p_sel;
  wire [3:0] n_sel;
  assign use_cw           = envelope | constant_wave;
  assign carrier_inverted = ~carrier;
  assign forced_low       = full_depth_ask_force & ~envelope & ~constant_wave;
  // output value is a don't-care while off; held low to keep the pad quiet
  assign wave = !carrier_on ? 1'b0 :
                forced_low ? 1'b0 :
                invert_when_on ? carrier_inverted : carrier;
  assign p_sel = !carrier_on ? `ADOC_OFF_SETTING :
                 use_cw ? p_cw_value : p_mod_value;
  assign n_sel = !carrier_on ? 4'(`ADOC_OFF_SETTING) :
                 use_cw ? n_cw_value : n_mod_value;
  // one assignment of the whole struct keeps the output a single driver
  assign drive = '{wave: wave, p_cond: p_sel, n_cond: n_sel};
endmodule // adoc_driver_leg

// ===== hdl/adoc_top.sv
// Our own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`include "adoc_defines.svh"
module adoc_top (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        tx_envelope,
  input  wire logic        ext_modem_in,
  output logic             ext_modem_out,
  output logic             antenna_out_a,
  output logic             antenna_out_b,
  output logic      [5:0]  pmos_a,
  output logic      [3:0]  nmos_a,
  output logic      [5:0]  pmos_b,
  output logic      [3:0]  nmos_b
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]           driver_control_reg;
  logic [5:0]           p_conductance_cw_reg;
  logic [5:0]           p_conductance_mod_reg;
  logic [7:0]           n_conductance_reg;
  logic [7:0]           transmit_mode_reg;
  logic [7:0]           transmit_signal_select_reg;
  adoc_pkg::adoc_req_t  req;
  logic                 carrier;
  logic [2:0]           modem_sync;
  logic                 ext_env;
  logic [7:0]           rate_cnt;
  logic                 rate_pulse;

  wire         take;
  wire         wr_en;
  wire [31:0]  next_rdata;
  assign take  = hsel & hready & htrans[1];
  assign wr_en = req.valid & req.write;

  // zero-wait slave: registered read data stands in the data phase
  always_ff @(posedge clk) begin
    if (rst) begin
      req <= '0;
    end else if (hready) begin
      req <= '{valid: take, write: hwrite, addr: haddr[7:0]};
    end
  end

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a[7:2] == b[7:2]);
  endfunction

  always_ff @(posedge clk) begin
    if (rst) begin
      driver_control_reg         <= `ADOC_CTL_RESET;
      p_conductance_cw_reg       <= `ADOC_P_CW_RESET;
      p_conductance_mod_reg      <= `ADOC_P_MOD_RESET;
      n_conductance_reg          <= `ADOC_N_RESET;
      transmit_mode_reg          <= `ADOC_MODE_RESET;
      transmit_signal_select_reg <= `ADOC_SEL_RESET;
    end else if (wr_en) begin
      if (hit(req.addr, `ADOC_DRIVER_CONTROL_ADDR)) driver_control_reg <= hwdata[7:0];
      if (hit(req.addr, `ADOC_P_COND_CW_ADDR)) p_conductance_cw_reg <= hwdata[5:0];
      if (hit(req.addr, `ADOC_P_COND_MOD_ADDR)) p_conductance_mod_reg <= hwdata[5:0];
      if (hit(req.addr, `ADOC_N_COND_ADDR)) n_conductance_reg <= hwdata[7:0];
      if (hit(req.addr, `ADOC_TRANSMIT_MODE_ADDR)) transmit_mode_reg <= hwdata[7:0];
      if (hit(req.addr, `ADOC_TRANSMIT_SEL_ADDR)) transmit_signal_select_reg <= hwdata[7:0];
    end
  end

  // read mux sampled in the address phase so hrdata is a flop output
  wire [7:0] ra;
  assign ra = haddr[7:0];
  assign next_rdata =
    hit(ra, `ADOC_DRIVER_CONTROL_ADDR) ? {24'h0, driver_control_reg} :
    hit(ra, `ADOC_P_COND_CW_ADDR)      ? {26'h0, p_conductance_cw_reg} :
    hit(ra, `ADOC_P_COND_MOD_ADDR)     ? {26'h0, p_conductance_mod_reg} :
    hit(ra, `ADOC_N_COND_ADDR)         ? {24'h0, n_conductance_reg} :
    hit(ra, `ADOC_TRANSMIT_MODE_ADDR)  ? {24'h0, transmit_mode_reg} :
    hit(ra, `ADOC_TRANSMIT_SEL_ADDR)   ? {24'h0, transmit_signal_select_reg} :
    hit(ra, `ADOC_STATUS_ADDR)         ? {12'h0, pmos_b, nmos_b, pmos_a, nmos_a} :
                                          32'h0;

  always_ff @(posedge clk) begin
    if (rst) begin
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (take & ~hwrite) begin
      hrdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // carrier: the clock stands in for the crystal, so a toggle halves it
  always_ff @(posedge clk) begin
    if (rst) begin
      carrier <= 1'b0;
    end else begin
      carrier <= ~carrier;
    end
  end

  // modem pin is asynchronous; third stage only confirms the second
  always_ff @(posedge clk) begin
    if (rst) begin
      modem_sync <= 3'h0;
      ext_env    <= 1'b1;
    end else begin
      modem_sync <= {modem_sync[1:0], ext_modem_in};
      if (modem_sync[2] == modem_sync[1]) ext_env <= modem_sync[2];
    end
  end

  // rate divider: coarse pacing for the internal envelope, shift 0 means full rate
  wire [2:0] rate_sel;
  assign rate_sel = transmit_mode_reg[`ADOC_MODE_RATE_MSB:`ADOC_MODE_RATE_LSB];
  wire [7:0] rate_limit;
  assign rate_limit = 8'((9'h1 << rate_sel) - 9'h1);
  always_ff @(posedge clk) begin
    if (rst) begin
      rate_cnt   <= 8'h0;
      rate_pulse <= 1'b0;
    end else begin
      rate_pulse <= (rate_cnt >= rate_limit);
      rate_cnt   <= (rate_cnt >= rate_limit) ? 8'h0 : rate_cnt + 8'h1;
    end
  end

  logic env_int;
  always_ff @(posedge clk) begin
    if (rst) begin
      env_int <= 1'b1;
    end else if (rate_pulse) begin
      env_int <= tx_envelope;
    end
  end

  adoc_pkg::adoc_env_src_t env_src;
  assign env_src = adoc_pkg::adoc_env_src_t'(
    transmit_signal_select_reg[`ADOC_SEL_ENV_MSB:`ADOC_SEL_ENV_LSB]);
  logic envelope;
  always_comb begin
    envelope = 1'b1;
    unique case (env_src)
      adoc_pkg::ADOC_ENV_CONST_HIGH: envelope = 1'b1;
      adoc_pkg::ADOC_ENV_INTERNAL:   envelope = env_int;
      adoc_pkg::ADOC_ENV_EXT_MODEM:  envelope = ext_env;
      adoc_pkg::ADOC_ENV_CONST_LOW:  envelope = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  wire drv1_carrier_on;
  wire drv2_carrier_on;
  wire drv2_constant_wave;
  wire full_depth_ask_force;
  wire [3:0] n_cw_value;
  wire [3:0] n_mod_value;
  assign drv1_carrier_on      = driver_control_reg[`ADOC_CTL_DRV1_ON];
  assign drv2_carrier_on      = driver_control_reg[`ADOC_CTL_DRV2_ON];
  assign drv2_constant_wave   = driver_control_reg[`ADOC_CTL_DRV2_CW];
  assign full_depth_ask_force = driver_control_reg[`ADOC_CTL_FULL_ASK];
  assign n_cw_value  = n_conductance_reg[`ADOC_NCW_MSB:`ADOC_NCW_LSB];
  assign n_mod_value = n_conductance_reg[`ADOC_N_MOD_VALUE_MSB:`ADOC_N_MOD_VALUE_LSB];

  // both legs read one shared register set, so two enabled drivers agree on
  // the values in use unless drv2's cw bit is set; a disabled leg drives the off setting
  adoc_pkg::adoc_drive_t drive_a;
  adoc_pkg::adoc_drive_t drive_b;
  adoc_driver_leg u_leg_a (
    .carrier              (carrier),
    .carrier_on           (drv1_carrier_on),
    .envelope             (envelope),
    .constant_wave        (1'b0),
    .invert_when_on       (driver_control_reg[`ADOC_CTL_DRV1_INV_ON]),
    .full_depth_ask_force (full_depth_ask_force),
    .p_cw_value           (p_conductance_cw_reg),
    .p_mod_value          (p_conductance_mod_reg),
    .n_cw_value           (n_cw_value),
    .n_mod_value          (n_mod_value),
    .drive                (drive_a)
  );
  adoc_driver_leg u_leg_b (
    .carrier              (carrier),
    .carrier_on           (drv2_carrier_on),
    .envelope             (envelope),
    .constant_wave        (drv2_constant_wave),
    .invert_when_on       (driver_control_reg[`ADOC_CTL_DRV2_INV_ON]),
    .full_depth_ask_force (full_depth_ask_force),
    .p_cw_value           (p_conductance_cw_reg),
    .p_mod_value          (p_conductance_mod_reg),
    .n_cw_value           (n_cw_value),
    .n_mod_value          (n_mod_value),
    .drive                (drive_b)
  );

  // one flop stage on all pad signals; carrier phase shifts by one cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      antenna_out_a <= 1'b0;
      antenna_out_b <= 1'b0;
      pmos_a        <= `ADOC_OFF_SETTING;
      nmos_a        <= 4'h0;
      pmos_b        <= `ADOC_OFF_SETTING;
      nmos_b        <= 4'h0;
      ext_modem_out <= 1'b1;
    end else begin
      antenna_out_a <= drive_a.wave;
      antenna_out_b <= drive_b.wave;
      pmos_a        <= drive_a.p_cond;
      nmos_a        <= drive_a.n_cond;
      pmos_b        <= drive_b.p_cond;
      nmos_b        <= drive_b.n_cond;
      ext_modem_out <= envelope;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_env_low;
    !envelope ##0 drv1_carrier_on;
  endsequence

  AST_CARRIER_DIV2: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |-> carrier != $past(carrier)) else $error("carrier did not toggle");
  AST_OFF_SETTING: assert property (@(posedge clk) disable iff (rst)
    !drv1_carrier_on |=> pmos_a == 6'h00 && nmos_a == 4'h0) else $error("off not applied");
  AST_MOD_P: assert property (@(posedge clk) disable iff (rst)
    s_env_low |=> pmos_a == $past(p_conductance_mod_reg)) else $error("pmos mod wrong");
  AST_MOD_N: assert property (@(posedge clk) disable iff (rst)
    s_env_low |=> nmos_a == $past(n_conductance_reg[3:0])) else $error("nmos mod wrong");
  AST_CW_N: assert property (@(posedge clk) disable iff (rst)
    envelope && drv1_carrier_on |=> nmos_a == $past(n_conductance_reg[7:4]))
    else $error("nmos cw wrong");
  AST_CW_P: assert property (@(posedge clk) disable iff (rst)
    envelope && drv1_carrier_on |=> pmos_a == $past(p_conductance_cw_reg))
    else $error("pmos cw wrong");
  AST_TX2_CW: assert property (@(posedge clk) disable iff (rst)
    drv2_carrier_on && drv2_constant_wave |=> pmos_b == $past(p_conductance_cw_reg))
    else $error("drv2 cw not forced");
  AST_FULL_ASK: assert property (@(posedge clk) disable iff (rst)
    s_env_low ##0 full_depth_ask_force |=> !antenna_out_a) else $error("ask not low");
  AST_INVERT: assert property (@(posedge clk) disable iff (rst)
    envelope && drv1_carrier_on && driver_control_reg[`ADOC_CTL_DRV1_INV_ON]
    |=> antenna_out_a == $past(!carrier))
    else $error("invert missing");
  AST_SHARED: assert property (@(posedge clk) disable iff (rst)
    drv1_carrier_on && drv2_carrier_on && envelope && !drv2_constant_wave |=> pmos_a == pmos_b)
    else $error("drivers disagree");

  // second driver: its own cw bit and inversion, same register set
  sequence s_b_mod;
    !envelope ##0 drv2_carrier_on ##0 !drv2_constant_wave;
  endsequence

  AST_OFF_B: assert property (@(posedge clk) disable iff (rst)
    !drv2_carrier_on |=> pmos_b == `ADOC_OFF_SETTING && nmos_b == 4'(`ADOC_OFF_SETTING))
    else $error("off not applied on b");
  AST_MOD_B: assert property (@(posedge clk) disable iff (rst)
    s_b_mod |=> pmos_b == $past(p_conductance_mod_reg) && nmos_b == $past(n_mod_value))
    else $error("drv2 mod wrong");
  AST_CW_B: assert property (@(posedge clk) disable iff (rst)
    envelope && drv2_carrier_on |=> nmos_b == $past(n_cw_value))
    else $error("drv2 cw n wrong");
  AST_ASK_B: assert property (@(posedge clk) disable iff (rst)
    s_b_mod ##0 full_depth_ask_force |=> !antenna_out_b)
    else $error("ask not low on b");
  AST_INVERT_B: assert property (@(posedge clk) disable iff (rst)
    envelope && drv2_carrier_on && driver_control_reg[`ADOC_CTL_DRV2_INV_ON]
    |=> antenna_out_b == $past(!carrier)) else $error("invert missing on b");
  AST_PLAIN_A: assert property (@(posedge clk) disable iff (rst)
    envelope && drv1_carrier_on && !driver_control_reg[`ADOC_CTL_DRV1_INV_ON]
    |=> antenna_out_a == $past(carrier)) else $error("carrier missing on a");

  // the bus never stalls or errors, so the master needs no retry path
  AST_BUS_OKAY: assert property (@(posedge clk) disable iff (rst)
    hreadyout && !hresp) else $error("bus answer not zero-wait okay");

  // a pulse always restarts the count, so back-to-back pulses mean full rate
  AST_RATE_GAP: assert property (@(posedge clk) disable iff (rst)
    rate_pulse && rate_limit != 8'h0 |=> !rate_pulse) else $error("rate pulses too close");
  AST_ENV_HOLD: assert property (@(posedge clk) disable iff (rst)
    !rate_pulse |=> env_int == $past(env_int)) else $error("envelope moved off pace");
  AST_ECHO: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> ext_modem_out == $past(envelope)) else $error("modem echo wrong");
endmodule // adoc_top

// ===== test/adoc_antenna_load.sv
`timescale 1ns/100ps
// passive antenna network: reports a field while its driver pin keeps switching
module adoc_antenna_load (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic drive_a,
  input  wire logic drive_b,
  output logic      field_a,
  output logic      field_b
);
  logic       last_a;
  logic       last_b;
  logic [2:0] age_a;
  logic [2:0] age_b;
  // a pin held still decays the field after a few cycles, like a damped tank
  always_ff @(posedge clk) begin
    last_a <= drive_a;
    last_b <= drive_b;
    if (rst) begin
      age_a <= 3'h7;
      age_b <= 3'h7;
    end else begin
      age_a <= (drive_a != last_a) ? 3'h0 : ((age_a == 3'h7) ? age_a : age_a + 3'h1);
      age_b <= (drive_b != last_b) ? 3'h0 : ((age_b == 3'h7) ? age_b : age_b + 3'h1);
    end
  end
  assign field_a = (age_a < 3'h3);
  assign field_b = (age_b < 3'h3);
endmodule // adoc_antenna_load

// ===== test/tb_adoc_top.sv
`timescale 1ns/100ps
`include "adoc_defines.svh"
module tb_adoc_top;
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hready;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, tx_envelope = 1'b1, ext_modem_in = 1'b0, ext_modem_out;
  logic antenna_out_a, antenna_out_b, field_a, field_b, prev;
  logic [5:0] pmos_a, pmos_b;
  logic [3:0] nmos_a, nmos_b;
  int err_total = 0, comparisons = 0;
  always #2 clk = ~clk;
  assign hready = hreadyout;
  adoc_top adoc_top_inst (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .tx_envelope(tx_envelope),
    .ext_modem_in(ext_modem_in), .ext_modem_out(ext_modem_out),
    .antenna_out_a(antenna_out_a), .antenna_out_b(antenna_out_b), .pmos_a(pmos_a),
    .nmos_a(nmos_a), .pmos_b(pmos_b), .nmos_b(nmos_b));
  adoc_antenna_load adoc_antenna_load_inst (.clk(clk), .rst(rst), .drive_a(antenna_out_a),
    .drive_b(antenna_out_b), .field_a(field_a), .field_b(field_b));
  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic fail(input string m);
    err_total++;
    $display("CHECK FAILED %0t %s", $time, m);
  endtask
  task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e, input string m);
    comparisons++;
    if (g !== e) fail(m);
  endtask
  task automatic cmp_drive(input logic [9:0] g, input logic [9:0] e, input string m);
    comparisons++;
    if (g !== e) fail(m);
  endtask
  task automatic cmp_bit(input logic g, input logic e, input string m);
    comparisons++;
    if (g !== e) fail(m);
  endtask
  // hready is sampled at every edge; a stuck bus ends the run instead of hanging
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1) begin
      fail("bus hang");
      wrap_up();
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    wait_ready();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_ready();
    q = hrdata;
    cmp_bit(hresp, 1'b0, "response not okay");
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    cmp_reg(q, e, "register read");
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(`ADOC_DRIVER_CONTROL_ADDR, 32'h80);
    rd(`ADOC_P_COND_CW_ADDR, 32'h3f);
    rd(`ADOC_P_COND_MOD_ADDR, 32'h20);
    rd(`ADOC_N_COND_ADDR, 32'h88);
    rd(`ADOC_TRANSMIT_MODE_ADDR, 32'h00);
    rd(`ADOC_TRANSMIT_SEL_ADDR, 32'h10);
    rd(8'h40, 32'h0);
    wr(`ADOC_P_COND_CW_ADDR, 32'h2a);
    wr(`ADOC_P_COND_MOD_ADDR, 32'h15);
    wr(`ADOC_N_COND_ADDR, 32'h5a);
    rd(`ADOC_P_COND_CW_ADDR, 32'h2a);
    rd(`ADOC_P_COND_MOD_ADDR, 32'h15);
    $display("test registers done");
    wr(`ADOC_TRANSMIT_SEL_ADDR, 32'h00);
    wr(`ADOC_DRIVER_CONTROL_ADDR, 32'h01);
    settle(6);
    cmp_drive({pmos_a, nmos_a}, {6'h2a, 4'h5}, "cw conductance a");
    cmp_drive({pmos_b, nmos_b}, 10'h0, "disabled b not off");
    prev = antenna_out_a;
    repeat (8) begin
      @(posedge clk);
      cmp_bit(antenna_out_a, ~prev, "carrier not half clock");
      prev = antenna_out_a;
    end
    cmp_bit(field_a, 1'b1, "no field on a");
    rd(`ADOC_STATUS_ADDR, {12'h0, 6'h0, 4'h0, 6'h2a, 4'h5});
    wr(`ADOC_TRANSMIT_SEL_ADDR, 32'h30);
    settle(6);
    cmp_drive({pmos_a, nmos_a}, {6'h15, 4'ha}, "mod conductance a");
    $display("test driver a done");
    wr(`ADOC_DRIVER_CONTROL_ADDR, 32'h06);
    settle(6);
    cmp_drive({pmos_b, nmos_b}, {6'h2a, 4'h5}, "cw bit ignored");
    cmp_drive({pmos_a, nmos_a}, 10'h0, "disabled a not off");
    wr(`ADOC_DRIVER_CONTROL_ADDR, 32'h02);
    settle(6);
    cmp_drive({pmos_b, nmos_b}, {6'h15, 4'ha}, "b mod values");
    $display("test driver b done");
    wr(`ADOC_TRANSMIT_SEL_ADDR, 32'h00);
    wr(`ADOC_DRIVER_CONTROL_ADDR, 32'h93);
    settle(6);
    repeat (6) begin
      @(posedge clk);
      cmp_bit(antenna_out_b, ~antenna_out_a, "b not inverse of a");
    end
    wr(`ADOC_TRANSMIT_SEL_ADDR, 32'h30);
    settle(6);
    repeat (6) begin
      @(posedge clk);
      cmp_bit(antenna_out_a | antenna_out_b, 1'b0, "forced low broken");
    end
    $display("test waveform done");
    wr(`ADOC_TRANSMIT_MODE_ADDR, 32'h00);
    wr(`ADOC_TRANSMIT_SEL_ADDR, 32'h20);
    ext_modem_in <= 1'b1;
    settle(10);
    cmp_drive({pmos_a, nmos_a}, {6'h2a, 4'h5}, "modem high not cw");
    cmp_bit(ext_modem_out, 1'b1, "modem echo high");
    ext_modem_in <= 1'b0;
    settle(10);
    cmp_drive({pmos_a, nmos_a}, {6'h15, 4'ha}, "modem low not mod");
    cmp_bit(ext_modem_out, 1'b0, "modem echo low");
    wr(`ADOC_TRANSMIT_SEL_ADDR, 32'h10);
    tx_envelope <= 1'b0;
    settle(40);
    cmp_drive({pmos_a, nmos_a}, {6'h15, 4'ha}, "internal low not mod");
    // shift 7: the envelope is sampled once in 128 cycles, counted from the mode write
    wr(`ADOC_TRANSMIT_MODE_ADDR, 32'h70);
    rd(`ADOC_TRANSMIT_MODE_ADDR, 32'h70);
    tx_envelope <= 1'b1;
    settle(4);
    cmp_drive({pmos_a, nmos_a}, {6'h15, 4'ha}, "slow rate followed too soon");
    settle(140);
    cmp_drive({pmos_a, nmos_a}, {6'h2a, 4'h5}, "slow rate never followed");
    $display("test envelope source done");
    wrap_up();
  end
endmodule // tb_adoc_top
